// [verification/pmc_power_mode_control_assertions.sv]
module pmc_power_mode_control_assertions
  import pmc_pkg::*;
(
  input wire logic        clock,
  input wire logic        arst_n,
  input wire pmc_req_t    req,
  input wire logic [7:0]  rdata,
  input wire logic        instr_done,
  input wire logic        irq_pending,
  input wire logic        watchdog_timeout,
  input wire logic        ext_reset,
  input wire pmc_ctl_t    ctl,
  input wire logic        cpu_rst_n,
  input wire logic [15:0] reset_vector
);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////
  // mode controls and their causes
  property p_vec; reset_vector == PMC_RESET_VECTOR; endproperty
  a_vec: assert property (p_vec) else $error("reset vector not zero");
  property p_idle; ctl.cpu_halt && ctl.osc_int_en |->
    !ctl.cpu_clk_en && ctl.periph_clk_en && ctl.irq_timer_en; endproperty
  a_idle: assert property (p_idle) else $error("idle clocks wrong");
  property p_stop; !ctl.osc_int_en |-> ctl.cpu_halt && !ctl.irq_timer_en &&
    !ctl.periph_clk_en && ctl.periph_gate == 8'h00; endproperty
  a_stop: assert property (p_stop) else $error("stop left a clock on");
  property p_ldo; !ctl.ldo_en |-> !ctl.osc_int_en; endproperty
  a_ldo: assert property (p_ldo) else $error("regulator off outside stop");
  // stop must outlast interrupts; only a reset source ends it
  property p_hold; !ctl.osc_int_en && !watchdog_timeout && !ext_reset &&
    !$past(watchdog_timeout) && !$past(ext_reset) |=> !ctl.osc_int_en; endproperty
  a_hold: assert property (p_hold) else $error("stop left without reset");
  property p_wake; ctl.cpu_halt && ctl.osc_int_en && irq_pending |->
    ##[1:2] !ctl.cpu_halt; endproperty
  a_wake: assert property (p_wake) else $error("interrupt did not wake");
  property p_cause; $rose(ctl.cpu_halt) |->
    $past(instr_done) || $past(instr_done, 2); endproperty
  a_cause: assert property (p_cause) else $error("halt before instruction end");
  property p_watchdog; watchdog_timeout |-> ##[1:2] (!cpu_rst_n && !ctl.cpu_halt); endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog gave no reset");
  property p_ext; ext_reset |-> ##[1:2] (!cpu_rst_n && ctl.osc_int_en); endproperty
  a_ext: assert property (p_ext) else $error("external reset ignored");
  // a short core reset pulse would let fetch start before state settles
  property p_len; $rose(cpu_rst_n) |-> !$past(cpu_rst_n, 4); endproperty
  a_len: assert property (p_len) else $error("core reset too short");
endmodule : pmc_power_mode_control_assertions

bind pmc_power_mode_control pmc_power_mode_control_assertions u_chk (
  .clock(clock), .arst_n(arst_n), .req(req), .rdata(rdata), .instr_done(instr_done),
  .irq_pending(irq_pending), .watchdog_timeout(watchdog_timeout), .ext_reset(ext_reset),
  .ctl(ctl), .cpu_rst_n(cpu_rst_n), .reset_vector(reset_vector)
);

// [verification/pmc_power_mode_control_bench.sv]
module pmc_power_mode_control_bench
  import pmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, arst_n, instr_done, irq_pending, watchdog_timeout, ext_reset, cpu_rst_n;
  pmc_req_t    req;
  logic [7:0]  rdata;
  pmc_ctl_t    ctl;
  logic [15:0] reset_vector;
  int          err_total, comparisons, cycles;
  logic [7:0]  stop_cfg [3] = '{8'h02, 8'h06, 8'h07};

  pmc_power_mode_control uut (
    .clock(clock), .arst_n(arst_n), .req(req), .rdata(rdata), .instr_done(instr_done),
    .irq_pending(irq_pending), .watchdog_timeout(watchdog_timeout), .ext_reset(ext_reset),
    .ctl(ctl), .cpu_rst_n(cpu_rst_n), .reset_vector(reset_vector)
  );

  // 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  ////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe, so look there
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    req.rd <= 1'b0;
    #1 check(16'(rdata), 16'(exp));
  endtask : rd
  // one-cycle event pulse: {ext_reset, watchdog_timeout, irq_pending, instr_done}
  task automatic pulse(input logic [3:0] m);
    @(posedge clock);
    {ext_reset, watchdog_timeout, irq_pending, instr_done} <= m;
    @(posedge clock);
    {ext_reset, watchdog_timeout, irq_pending, instr_done} <= 4'h0;
    repeat (3) @(posedge clock);
    #1;
  endtask : pulse
  // f = {halt, cpu clk, periph clk, irq/timer, int osc, regulator}
  task automatic ctl_is(input logic [5:0] f, input logic [7:0] g);
    check(16'(ctl), {2'h0, f, g});
  endtask : ctl_is
  task automatic print_verdict;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  // hang guard, far above the under two hundred cycles the sequence needs
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total++;
      print_verdict();
    end
  end

  ////////////////////////////////////////
  initial begin
    err_total = 0;
    comparisons = 0;
    cycles = 0;
    arst_n = 1'b0;
    req = '0;
    {ext_reset, watchdog_timeout, irq_pending, instr_done} = 4'h0;
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    rd(PMC_ADDR_PCR, PMC_PCR_RESET);
    rd(PMC_ADDR_CKGATE, PMC_CKGATE_RESET);
    rd(PMC_ADDR_STATUS, 8'h00);
    ctl_is(6'h1F, 8'h00);
    check(16'(cpu_rst_n), 16'h0001);
    check(reset_vector, PMC_RESET_VECTOR);
    // gates, and a write to an unmapped place must disturb nothing
    wr(PMC_ADDR_CKGATE, 8'hA5);
    wr(4'hF, 8'hFF);
    rd(4'hF, PMC_UNMAPPED);
    rd(PMC_ADDR_CKGATE, 8'hA5);
    ctl_is(6'h1F, 8'hA5);
    // idle with a flag bit kept, then interrupt wake
    wr(PMC_ADDR_PCR, 8'h09);
    // the idle write is followed by a second single-byte write of the same value
    wr(PMC_ADDR_PCR, 8'h09);
    rd(PMC_ADDR_PCR, 8'h09);
    pulse(4'h1);
    ctl_is(6'h2F, 8'hA5);
    rd(PMC_ADDR_STATUS, 8'h01);
    rd(PMC_ADDR_CKGATE, 8'hA5);
    pulse(4'h2);
    ctl_is(6'h1F, 8'hA5);
    rd(PMC_ADDR_PCR, 8'h08);
    rd(PMC_ADDR_STATUS, 8'h08);
    rd(PMC_ADDR_STATUS, 8'h00);
    check(16'(cpu_rst_n), 16'h0001);
    // watchdog ends idle through a full reset
    wr(PMC_ADDR_PCR, 8'h01);
    pulse(4'h1);
    pulse(4'h4);
    check(16'(cpu_rst_n), 16'h0000);
    ctl_is(6'h1F, 8'h00);
    repeat (8) @(posedge clock);
    rd(PMC_ADDR_STATUS, 8'h04);
    rd(PMC_ADDR_PCR, 8'h00);
    check(16'(cpu_rst_n), 16'h0001);
    // stop with regulator on, off, and stop winning over idle
    foreach (stop_cfg[i]) begin
      wr(PMC_ADDR_CKGATE, 8'hFF);
      wr(PMC_ADDR_PCR, stop_cfg[i]);
      pulse(4'h1);
      ctl_is({5'h10, ~stop_cfg[i][2]}, 8'h00);
      rd(PMC_ADDR_STATUS, 8'h02);
      pulse(4'h2);
      ctl_is({5'h10, ~stop_cfg[i][2]}, 8'h00);
      pulse(4'h8);
      check(16'(cpu_rst_n), 16'h0000);
      ctl_is(6'h1F, 8'h00);
      repeat (8) @(posedge clock);
    end
    print_verdict();
  end
endmodule : pmc_power_mode_control_bench

// [verilog/pmc_pkg.sv]
package pmc_pkg;

  // register indices on the plain register port (byte-wide data)
  localparam logic [3:0] PMC_ADDR_PCR    = 4'h0;  // power_control_register
  localparam logic [3:0] PMC_ADDR_STATUS = 4'h1;  // mode and wake-cause status
  localparam logic [3:0] PMC_ADDR_CKGATE = 4'h2;  // digital peripheral clock enables

  // power_control_register fields
  localparam int PMC_PCR_IDLE_BIT = 0;
  localparam int PMC_PCR_STOP_BIT = 1;
  localparam int PMC_PCR_LDO_BIT  = 2;  // regulator off while stopped
  localparam int PMC_PCR_GF_LSB   = 3;  // general-purpose flag bits
  localparam int PMC_PCR_GF_W     = 5;

  // status fields
  localparam int PMC_ST_IDLE_BIT  = 0;
  localparam int PMC_ST_STOP_BIT  = 1;
  localparam int PMC_ST_WDRST_BIT = 2;
  localparam int PMC_ST_IRQW_BIT  = 3;

  // reset values
  localparam logic [7:0] PMC_PCR_RESET    = 8'h00;
  localparam logic [7:0] PMC_CKGATE_RESET = 8'h00;
  localparam logic [7:0] PMC_UNMAPPED     = 8'h00;

  // core reset hold count; the core stays in reset this many clock cycles plus one after any reset source
  localparam int unsigned PMC_RST_HOLD    = 4;

  // number of gated digital peripheral clocks
  localparam int PMC_NUM_PERIPH = 8;

  // address executed after any reset
  localparam logic [15:0] PMC_RESET_VECTOR = 16'h0000;

  typedef enum logic [1:0] {
    PMC_RUN,
    PMC_IDLE,
    PMC_STOP
  } pmc_state_t;

  // register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pmc_req_t;

  // power and clock controls toward the rest of the chip
  typedef struct packed {
    logic                      cpu_halt;
    logic                      cpu_clk_en;
    logic                      periph_clk_en;
    logic                      irq_timer_en;
    logic                      osc_int_en;
    logic                      ldo_en;
    logic [PMC_NUM_PERIPH-1:0] periph_gate;
  } pmc_ctl_t;

endpackage : pmc_pkg

// [verilog/pmc_power_mode_control.sv]
// Function
// - setting idle bit halts cpu after the writing instruction completes
// - idle keeps registers, memory, peripheral clocks and peripherals running; only the cpu clock stops
// - enabled interrupt in idle clears idle bit and resumes the cpu
// - after interrupt return, execution continues after the idle-setting instruction
// - reset ending idle runs normal reset sequence from address zero
// - stop halts cpu, interrupts, timers, internal oscillator; external oscillator unaffected
// - regulator may be disabled during stop mode
// - watchdog timeout while idle gives internal reset ending idle
// - unused digital peripherals have their clocks gated off
module pmc_power_mode_control
  import pmc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire pmc_req_t    req,
  output logic [7:0]       rdata,
  input  wire logic        instr_done,
  input  wire logic        irq_pending,
  input  wire logic        watchdog_timeout,
  input  wire logic        ext_reset,
  output pmc_ctl_t         ctl,
  output logic             cpu_rst_n,
  output logic [15:0]      reset_vector
);

  pmc_state_t       state_reg;
  pmc_state_t       state_next;
  logic             idle_reg;
  logic             stop_reg;
  logic             ldo_off_reg;
  logic [PMC_PCR_GF_W-1:0] gf_reg;
  logic [7:0]       ckgate_reg;
  logic             wdrst_reg;
  logic             irqw_reg;
  logic             pend_idle_reg;
  logic             pend_stop_reg;
  logic             reset_evt;
  logic             wr_pcr;
  logic             irq_wake;

  function automatic logic hit(input pmc_req_t r, input logic [3:0] a);
    hit = (r.addr == a);
  endfunction : hit

  assign wr_pcr    = req.wr && hit(req, PMC_ADDR_PCR);
  // a watchdog timeout or pin reset both restart the core; these two are the
  // only ways out of an idle that no interrupt will ever end
  assign reset_evt = ext_reset || watchdog_timeout;
  // interrupts are dead in stop, so only idle wakes on them
  assign irq_wake  = (state_reg == PMC_IDLE) && irq_pending;

  ////////////////////////////////////////////////////////////////////////
  // mode requests are latched by the write and acted on at instruction end;
  // an instr_done in the write cycle belongs to an earlier instruction, so it
  // must not start the mode change (the write takes priority over it)
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pend_idle_reg <= 1'b0;
      pend_stop_reg <= 1'b0;
    end else if (reset_evt || state_reg != PMC_RUN) begin
      pend_idle_reg <= 1'b0;
      pend_stop_reg <= 1'b0;
    end else if (wr_pcr) begin
      pend_idle_reg <= req.wdata[PMC_PCR_IDLE_BIT];
      pend_stop_reg <= req.wdata[PMC_PCR_STOP_BIT];
    end else if (instr_done) begin
      pend_idle_reg <= 1'b0;
      pend_stop_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode state machine; stop wins when both bits are written together
  // interrupts are ignored in stop: with no clock a wake would be lost anyway,
  // so reset is the single exit and the core restarts from its vector
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PMC_RUN: begin
        if (instr_done && pend_stop_reg) begin
          state_next = PMC_STOP;
        end else if (instr_done && pend_idle_reg) begin
          state_next = PMC_IDLE;
        end
      end
      PMC_IDLE: begin
        if (irq_wake) begin
          state_next = PMC_RUN;
        end
      end
      PMC_STOP: begin
        state_next = PMC_STOP;
      end
      default: begin
        state_next = PMC_RUN;
      end
    endcase
    if (reset_evt) begin
      state_next = PMC_RUN;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= PMC_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power_control_register: idle and stop bits read back the pending request from the write on, then the live mode
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      idle_reg    <= PMC_PCR_RESET[PMC_PCR_IDLE_BIT];
      stop_reg    <= PMC_PCR_RESET[PMC_PCR_STOP_BIT];
      ldo_off_reg <= PMC_PCR_RESET[PMC_PCR_LDO_BIT];
      gf_reg      <= PMC_PCR_RESET[PMC_PCR_GF_LSB +: PMC_PCR_GF_W];
    end else if (reset_evt) begin
      idle_reg    <= 1'b0;
      stop_reg    <= 1'b0;
      ldo_off_reg <= 1'b0;
      gf_reg      <= PMC_PCR_RESET[PMC_PCR_GF_LSB +: PMC_PCR_GF_W];
    end else begin
      idle_reg <= (state_next == PMC_IDLE) || (wr_pcr && req.wdata[PMC_PCR_IDLE_BIT])
                  || (pend_idle_reg && state_reg == PMC_RUN && !instr_done);
      if (irq_wake) begin
        idle_reg <= 1'b0;
      end
      stop_reg <= (state_next == PMC_STOP) || (wr_pcr && req.wdata[PMC_PCR_STOP_BIT])
                  || (pend_stop_reg && state_reg == PMC_RUN && !instr_done);
      if (wr_pcr) begin
        ldo_off_reg <= req.wdata[PMC_PCR_LDO_BIT];
        gf_reg      <= req.wdata[PMC_PCR_GF_LSB +: PMC_PCR_GF_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // peripheral clock enables; reset leaves every unused peripheral gated
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ckgate_reg <= PMC_CKGATE_RESET;
    end else if (reset_evt) begin
      ckgate_reg <= PMC_CKGATE_RESET;
    end else if (req.wr && hit(req, PMC_ADDR_CKGATE)) begin
      ckgate_reg <= req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wake-cause flags; a new event in the read cycle wins over read-clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wdrst_reg <= 1'b0;
      irqw_reg  <= 1'b0;
    end else begin
      if (watchdog_timeout) begin
        wdrst_reg <= 1'b1;
      end else if (ext_reset || (req.rd && hit(req, PMC_ADDR_STATUS))) begin
        wdrst_reg <= 1'b0;
      end
      if (irq_wake) begin
        irqw_reg <= 1'b1;
      end else if (reset_evt || (req.rd && hit(req, PMC_ADDR_STATUS))) begin
        irqw_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data one cycle after the strobe; unmapped reads return zero
  // status flags clear on the read strobe itself, not on the data cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= PMC_UNMAPPED;
    end else if (req.rd) begin
      if (hit(req, PMC_ADDR_PCR)) begin
        rdata <= {gf_reg, ldo_off_reg, stop_reg, idle_reg};
      end else if (hit(req, PMC_ADDR_STATUS)) begin
        rdata <= {4'h0, irqw_reg, wdrst_reg, state_reg == PMC_STOP, state_reg == PMC_IDLE};
      end else if (hit(req, PMC_ADDR_CKGATE)) begin
        rdata <= ckgate_reg;
      end else begin
        rdata <= PMC_UNMAPPED;
      end
    end else begin
      rdata <= PMC_UNMAPPED;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power controls; idle only halts the cpu so its pc and state are held
  // driven from state_next so the enables change on the same edge as the mode,
  // at the cost of a longer path through the decode
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctl <= '{cpu_halt: 1'b0, cpu_clk_en: 1'b1, periph_clk_en: 1'b1, irq_timer_en: 1'b1,
               osc_int_en: 1'b1, ldo_en: 1'b1, periph_gate: PMC_CKGATE_RESET};
    end else begin
      ctl.cpu_halt      <= (state_next != PMC_RUN);
      ctl.cpu_clk_en    <= (state_next == PMC_RUN);
      ctl.periph_clk_en <= (state_next != PMC_STOP);
      ctl.irq_timer_en  <= (state_next != PMC_STOP);
      ctl.osc_int_en    <= (state_next != PMC_STOP);
      ctl.ldo_en        <= !((state_next == PMC_STOP) && ldo_off_reg);
      ctl.periph_gate   <= (state_next == PMC_STOP) ? 8'h00 : ckgate_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // normal reset sequence for the core
  pmc_reset_seq u_reset_seq (
    .clock     (clock),
    .arst_n    (arst_n),
    .trigger   (reset_evt),
    .cpu_rst_n (cpu_rst_n)
  );

  assign reset_vector = PMC_RESET_VECTOR;

endmodule : pmc_power_mode_control

// [verilog/pmc_reset_seq.sv]
// holds the cpu in reset for a fixed number of cycles after any reset source
module pmc_reset_seq
  import pmc_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = PMC_RST_HOLD
) (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic trigger,
  output logic      cpu_rst_n
);

  logic [3:0] cnt_reg;

  ////////////////////////////////////////////////////////////////////////
  // restart the count on every trigger; release once it runs out
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 4'h0;
    end else if (trigger) begin
      cnt_reg <= 4'h0;
    end else if (cnt_reg != HOLD_CYCLES[3:0]) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cpu_rst_n <= 1'b0;
    end else begin
      cpu_rst_n <= (cnt_reg == HOLD_CYCLES[3:0]) && !trigger;
    end
  end

endmodule : pmc_reset_seq
